// >>> rtl/ici_pkg.sv
// shared constants, types and decoding for the indirect command interpreter
package ici_pkg;

  // ----------------------------------------------------------------
  // command codes
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_SYS_SET = 8'h40;
  localparam logic [7:0] CMD_STANDBY = 8'h53;
  localparam logic [7:0] CMD_DISP_OFF = 8'h58;
  localparam logic [7:0] CMD_DISP_ON = 8'h59;
  localparam logic [7:0] CMD_SCREEN_BLOCK = 8'h44;
  localparam logic [7:0] CMD_CUR_SHAPE = 8'h5d;
  localparam logic [7:0] CMD_CUR_DIR_LO = 8'h4c;
  localparam logic [7:0] CMD_CUR_DIR_HI = 8'h4f;
  localparam logic [7:0] CMD_OVERLAY = 8'h5b;
  localparam logic [7:0] CMD_GLYPH_BASE = 8'h5c;
  localparam logic [7:0] CMD_FINE_HSCROLL = 8'h5a;
  localparam logic [7:0] CMD_PIXEL_DEPTH = 8'h60;
  localparam logic [7:0] CMD_CUR_SET = 8'h46;
  localparam logic [7:0] CMD_CUR_GET = 8'h47;
  localparam logic [7:0] CMD_MEM_STORE = 8'h42;
  localparam logic [7:0] CMD_MEM_FETCH = 8'h43;

  // ----------------------------------------------------------------
  // register addresses, parameter counts, field masks
  // ----------------------------------------------------------------
  localparam logic [15:0] ADDR_SYS_SET = 16'h8000;
  localparam logic [15:0] ADDR_STANDBY_CONTROL = 16'h8008;
  localparam logic [15:0] ADDR_DISPLAY_ATTRIBUTE = 16'h800a;
  localparam logic [15:0] ADDR_SCREEN_BLOCK = 16'h800b;
  localparam logic [15:0] ADDR_CUR_SHAPE = 16'h8015;
  localparam logic [15:0] ADDR_CURSOR_DIRECTION = 16'h8017;
  localparam logic [15:0] ADDR_OVERLAY_FORMAT = 16'h8018;
  localparam logic [15:0] ADDR_GLYPH_BASE = 16'h8019;
  localparam logic [15:0] ADDR_FINE_SCROLL_POSITION = 16'h801b;
  localparam logic [15:0] ADDR_CUR_SET = 16'h801c;
  localparam logic [15:0] ADDR_PIXEL_DEPTH_SELECT = 16'h8020;
  localparam int REG_COUNT = 33;
  localparam logic [3:0] LEN_SYS_SET = 4'h8;
  localparam logic [3:0] LEN_SCREEN_BLOCK = 4'ha;
  localparam logic [3:0] LEN_PAIR = 4'h2;
  localparam logic [3:0] LEN_SINGLE = 4'h1;
  localparam logic [7:0] SYS_P1_KEEP_MASK = 8'h2d;
  localparam logic [7:0] SYS_P1_ONE_MASK = 8'h10;
  localparam logic [7:0] PIXEL_DEPTH_MASK = 8'h03;
  localparam logic [7:0] CUR_DIR_MASK = 8'h03;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic STANDBY_RESET = 1'b1;
  localparam int MEM_AW = 10;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 10000000;
  localparam int INIT_WAIT_MS = 3;
  localparam int INIT_WAIT_CYC = CLK_HZ / 1000 * INIT_WAIT_MS;
  localparam logic [3:0] ACC_STROBE_CYC = 4'h8;
  localparam logic [3:0] ACC_GAP_CYC = 4'h4;
  localparam int SYNC_W = 16;
  // idle pins: strobes deasserted, active-low ones high
  localparam logic [15:0] SYNC_IDLE = 16'h1900;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    BUS_GENERIC = 2'h0,
    BUS_ENABLE = 2'h1,
    BUS_LDS = 2'h2
  } ici_bus_mode_t;

  typedef enum logic [1:0] {
    ACC_NONE = 2'h0,
    ACC_CMD_WR = 2'h1,
    ACC_PAR_WR = 2'h2,
    ACC_DATA_RD = 2'h3
  } ici_acc_t;

  typedef enum logic [4:0] {
    HST_IDLE = 5'b00001,
    HST_SETUP = 5'b00010,
    HST_STROBE = 5'b00100,
    HST_GAP = 5'b01000,
    HST_SETTLE = 5'b10000
  } ici_host_state_t;

  function automatic logic [5:0] reg_idx(input logic [15:0] addr);
    reg_idx = addr[5:0];
  endfunction

  function automatic ici_acc_t decode_access(input ici_bus_mode_t mode, input logic rs,
                                             input logic wr_n, input logic rd_n,
                                             input logic rw, input logic en,
                                             input logic lds_n);
    logic act;
    act = (mode == BUS_ENABLE) ? en : !lds_n;
    decode_access = ACC_NONE;
    if (mode == BUS_GENERIC)
    begin
      if (rs && !wr_n && rd_n)
        decode_access = ACC_CMD_WR;
      else if (rs && wr_n && !rd_n)
        decode_access = ACC_DATA_RD;
      else if (!rs && !wr_n && rd_n)
        decode_access = ACC_PAR_WR;
    end
    else if (act)
    begin
      if (rs && !rw)
        decode_access = ACC_CMD_WR;
      else if (rs && rw)
        decode_access = ACC_DATA_RD;
      else if (!rs && !rw)
        decode_access = ACC_PAR_WR;
    end
  endfunction

endpackage

// >>> rtl/ici_bus_if.sv
// parallel host bus between the host end and the device end
`timescale 1ns/1ps
interface ici_bus_if;
  logic register_select;
  logic wr_n;
  logic rd_n;
  logic rw;
  logic en;
  logic lower_byte_strobe_n;
  logic [7:0] host_data;
  logic host_data_oe;
  logic [7:0] dev_data;
  logic dev_data_oe;
  logic [7:0] data;

  // resolved data wire; an undriven bus floats high
  assign data = host_data_oe ? host_data : (dev_data_oe ? dev_data : 8'hff);

  modport host (
    output register_select, wr_n, rd_n, rw, en, lower_byte_strobe_n,
    output host_data, host_data_oe,
    input data
  );

  modport dev (
    input register_select, wr_n, rd_n, rw, en, lower_byte_strobe_n,
    output dev_data, dev_data_oe,
    input data
  );
endinterface

// >>> rtl/ici_sync2.sv
// two-flop synchroniser for a vector of pin inputs
`timescale 1ns/1ps
module ici_sync2 #(
  parameter int W = 8,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta_reg;
  logic [W-1:0] meta_next;
  logic [W-1:0] q_reg;
  logic [W-1:0] q_next;

  always_comb
  begin
    meta_next = d_i;
    q_next = meta_reg;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      meta_reg <= INIT;
      q_reg <= INIT;
    end
    else if (ce_i)
    begin
      meta_reg <= meta_next;
      q_reg <= q_next;
    end
  end

  assign q_o = q_reg;
endmodule

// >>> rtl/ici_device.sv
// device end: indirect-mode command interpreter with register file and display memory
//
// Behaviour
// R1 - init 40h takes 8 bytes at 8000h
// R2 - standby 53h, no bytes, enters standby
// R3 - display on/off 59h/58h, byte to 800Ah
// R4 - screen block 44h, 10 bytes 800Bh-8014h
// R5 - cursor shape 5Dh; direction 4Ch-4Fh to 8017h
// R6 - overlay 5Bh, one byte to 8018h
// R7 - glyph RAM base 5Ch, two bytes 8019h
// R8 - fine scroll 5Ah, one byte to 801Bh
// R9 - pixel depth 60h, one byte to 8020h
// R10 - cursor set 46h; memory store/fetch unbounded
// R11 - cursor get 47h reads low then high
// R12 - generic bus select and strobe decoding
// R13 - enable-strobed bus decoding, enable high
// R14 - lower-byte-strobe bus decoding, strobe low
// R15 - starts in standby; init restores normal
// R16 - host waits 3 ms after init code when CRYSTAL_I is high
// R17 - init first byte fixed bits forced
// R18 - init bytes 2 and 4-8 stored whole
// R19 - pixel depth decode 1/2/4, 11 reserved
// R20 - cursor moves only by set or access
// R21 - count bytes per command; new command restarts
`timescale 1ns/1ps
module ici_device
  import ici_pkg::*;
(
  input wire logic CLK_SYS_I,
  input wire logic RST_I,
  input wire logic CE_I,
  input wire logic [1:0] BUS_MODE_I,
  ici_bus_if.dev BUS,
  input wire logic [5:0] CFG_IDX_I,
  output logic [7:0] CFG_DATA_O,
  output logic STANDBY_O,
  output logic NORMAL_O,
  output logic DISPLAY_ON_O,
  output logic [15:0] CURSOR_O,
  output logic [2:0] BPP_O
);
  // ----------------------------------------------------------------
  // pin synchronisation and access decode
  // ----------------------------------------------------------------
  logic [SYNC_W-1:0] pins_s;
  ici_acc_t acc;
  ici_acc_t acc_prev_reg;
  ici_acc_t acc_prev_next;
  logic start;

  ici_sync2 #(.W(SYNC_W), .INIT(SYNC_IDLE)) u_sync (
    .clk_i(CLK_SYS_I),
    .rst_i(RST_I),
    .ce_i(CE_I),
    .d_i({BUS_MODE_I, BUS.register_select, BUS.wr_n, BUS.rd_n, BUS.rw, BUS.en,
          BUS.lower_byte_strobe_n, BUS.data}),
    .q_o(pins_s)
  );

  // R12 R13 R14
  assign acc = decode_access(ici_bus_mode_t'(pins_s[15:14]), pins_s[13], pins_s[12],
                             pins_s[11], pins_s[10], pins_s[9], pins_s[8]);
  // one action per access: act on the edge where the decoded access appears
  assign start = (acc != ACC_NONE) && (acc_prev_reg == ACC_NONE);

  // ----------------------------------------------------------------
  // command tables
  // ----------------------------------------------------------------
  function automatic logic [5:0] cmd_base(input logic [7:0] cmd);
    case (cmd)
      CMD_SYS_SET: cmd_base = reg_idx(ADDR_SYS_SET);
      CMD_DISP_ON, CMD_DISP_OFF: cmd_base = reg_idx(ADDR_DISPLAY_ATTRIBUTE);
      CMD_SCREEN_BLOCK: cmd_base = reg_idx(ADDR_SCREEN_BLOCK);
      CMD_CUR_SHAPE: cmd_base = reg_idx(ADDR_CUR_SHAPE);
      CMD_OVERLAY: cmd_base = reg_idx(ADDR_OVERLAY_FORMAT);
      CMD_GLYPH_BASE: cmd_base = reg_idx(ADDR_GLYPH_BASE);
      CMD_FINE_HSCROLL: cmd_base = reg_idx(ADDR_FINE_SCROLL_POSITION);
      CMD_CUR_SET: cmd_base = reg_idx(ADDR_CUR_SET);
      CMD_PIXEL_DEPTH: cmd_base = reg_idx(ADDR_PIXEL_DEPTH_SELECT);
      default: cmd_base = 6'h00;
    endcase
  endfunction

  function automatic logic [3:0] cmd_len(input logic [7:0] cmd);
    case (cmd)
      CMD_SYS_SET: cmd_len = LEN_SYS_SET; // R1
      CMD_DISP_ON, CMD_DISP_OFF: cmd_len = LEN_SINGLE; // R3
      CMD_SCREEN_BLOCK: cmd_len = LEN_SCREEN_BLOCK; // R4
      CMD_CUR_SHAPE: cmd_len = LEN_PAIR; // R5
      CMD_OVERLAY: cmd_len = LEN_SINGLE; // R6
      CMD_GLYPH_BASE: cmd_len = LEN_PAIR; // R7
      CMD_FINE_HSCROLL: cmd_len = LEN_SINGLE; // R8
      CMD_CUR_SET: cmd_len = LEN_PAIR; // R10
      CMD_PIXEL_DEPTH: cmd_len = LEN_SINGLE; // R9
      default: cmd_len = 4'h0;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // interpreter state
  // ----------------------------------------------------------------
  logic [7:0] cmd_reg;
  logic [7:0] cmd_next;
  logic [3:0] cnt_reg;
  logic [3:0] cnt_next;
  logic standby_reg;
  logic standby_next;
  logic sys_done_reg;
  logic sys_done_next;
  logic disp_on_reg;
  logic disp_on_next;
  logic [15:0] cursor_reg;
  logic [15:0] cursor_next;
  logic get_hi_reg;
  logic get_hi_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic rd_oe_reg;
  logic rd_oe_next;
  logic [7:0] cfg_reg;
  logic [7:0] cfg_next;
  logic [7:0] regs_reg [REG_COUNT];
  logic [7:0] regs_next [REG_COUNT];
  logic [7:0] mem [2**MEM_AW];
  logic mem_we;
  logic [7:0] mem_rd;
  logic [7:0] din;
  logic [5:0] wr_idx;

  assign din = pins_s[7:0];
  assign mem_rd = mem[cursor_reg[MEM_AW-1:0]];
  assign wr_idx = 6'(cmd_base(cmd_reg) + {2'h0, cnt_reg});

  always_comb
  begin
    acc_prev_next = acc;
    cmd_next = cmd_reg;
    cnt_next = cnt_reg;
    standby_next = standby_reg;
    sys_done_next = sys_done_reg;
    disp_on_next = disp_on_reg;
    cursor_next = cursor_reg;
    get_hi_next = get_hi_reg;
    rdata_next = rdata_reg;
    rd_oe_next = rd_oe_reg && (acc == ACC_DATA_RD);
    regs_next = regs_reg;
    mem_we = 1'b0;
    if (start)
    begin
      case (acc)
        ACC_CMD_WR:
        begin
          cmd_next = din;
          cnt_next = 4'h0; // R21
          get_hi_next = 1'b0; // R11
          if (din == CMD_STANDBY)
            standby_next = 1'b1; // R2
          if (din == CMD_SYS_SET)
          begin
            standby_next = 1'b0; // R15
            sys_done_next = 1'b0;
          end
          if (din == CMD_DISP_ON || din == CMD_DISP_OFF)
            disp_on_next = din[0]; // R3
          if (din >= CMD_CUR_DIR_LO && din <= CMD_CUR_DIR_HI)
            regs_next[reg_idx(ADDR_CURSOR_DIRECTION)] = din & CUR_DIR_MASK; // R5
        end
        ACC_PAR_WR:
        begin
          if (cmd_reg == CMD_MEM_STORE)
          begin
            mem_we = 1'b1; // R10
            cursor_next = 16'(cursor_reg + 16'h0001); // R20
          end
          else if (cnt_reg < cmd_len(cmd_reg))
          begin
            // R1 R4 R5 R6 R7 R8 R18 R21
            regs_next[wr_idx] = din;
            if (cmd_reg == CMD_SYS_SET && cnt_reg == 4'h0)
              regs_next[wr_idx] = (din & SYS_P1_KEEP_MASK) | SYS_P1_ONE_MASK; // R17
            if (cmd_reg == CMD_PIXEL_DEPTH)
              regs_next[wr_idx] = din & PIXEL_DEPTH_MASK; // R9
            if (cmd_reg == CMD_CUR_SET)
            begin
              // R20
              if (cnt_reg == 4'h0)
                cursor_next[7:0] = din;
              else
                cursor_next[15:8] = din;
            end
            if (cmd_reg == CMD_SYS_SET && cnt_reg == 4'(LEN_SYS_SET - 4'h1))
              sys_done_next = 1'b1; // R15
            cnt_next = 4'(cnt_reg + 4'h1);
          end
        end
        ACC_DATA_RD:
        begin
          rd_oe_next = 1'b1;
          if (cmd_reg == CMD_CUR_GET)
          begin
            rdata_next = get_hi_reg ? cursor_reg[15:8] : cursor_reg[7:0]; // R11
            get_hi_next = !get_hi_reg;
          end
          else
          begin
            rdata_next = mem_rd; // R10
            if (cmd_reg == CMD_MEM_FETCH)
              cursor_next = 16'(cursor_reg + 16'h0001); // R20
          end
        end
        default:
        begin
        end
      endcase
    end
    if (CFG_IDX_I == reg_idx(ADDR_STANDBY_CONTROL))
      cfg_next = {7'h00, standby_reg};
    else if (int'(CFG_IDX_I) < REG_COUNT)
      cfg_next = regs_reg[CFG_IDX_I];
    else
      cfg_next = REG_RESET;
  end

  always_ff @(posedge CLK_SYS_I)
  begin
    if (RST_I)
    begin
      acc_prev_reg <= ACC_NONE;
      cmd_reg <= REG_RESET;
      cnt_reg <= 4'h0;
      standby_reg <= STANDBY_RESET; // R15
      sys_done_reg <= 1'b0;
      disp_on_reg <= 1'b0;
      cursor_reg <= 16'h0000;
      get_hi_reg <= 1'b0;
      rdata_reg <= REG_RESET;
      rd_oe_reg <= 1'b0;
      cfg_reg <= REG_RESET;
      for (int i = 0; i < REG_COUNT; i++)
        regs_reg[i] <= REG_RESET;
    end
    else if (CE_I)
    begin
      acc_prev_reg <= acc_prev_next;
      cmd_reg <= cmd_next;
      cnt_reg <= cnt_next;
      standby_reg <= standby_next;
      sys_done_reg <= sys_done_next;
      disp_on_reg <= disp_on_next;
      cursor_reg <= cursor_next;
      get_hi_reg <= get_hi_next;
      rdata_reg <= rdata_next;
      rd_oe_reg <= rd_oe_next;
      cfg_reg <= cfg_next;
      regs_reg <= regs_next;
    end
  end

  // display memory has no reset; software clears it through store commands
  always_ff @(posedge CLK_SYS_I)
  begin
    if (CE_I && !RST_I && mem_we)
      mem[cursor_reg[MEM_AW-1:0]] <= din;
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  always_comb
  begin
    // R19
    case (regs_reg[reg_idx(ADDR_PIXEL_DEPTH_SELECT)][1:0])
      2'h0: BPP_O = 3'h1;
      2'h1: BPP_O = 3'h2;
      2'h2: BPP_O = 3'h4;
      default: BPP_O = 3'h0;
    endcase
  end

  assign BUS.dev_data = rdata_reg;
  assign BUS.dev_data_oe = rd_oe_reg;
  assign CFG_DATA_O = cfg_reg;
  assign STANDBY_O = standby_reg;
  assign NORMAL_O = !standby_reg && sys_done_reg; // R15
  assign DISPLAY_ON_O = disp_on_reg;
  assign CURSOR_O = cursor_reg;
endmodule

// >>> rtl/ici_host.sv
// host end: drives command, parameter and read accesses onto the parallel bus
`timescale 1ns/1ps
module ici_host
  import ici_pkg::*;
#(
  parameter int INIT_WAIT = INIT_WAIT_CYC
) (
  input wire logic CLK_SYS_I,
  input wire logic RST_I,
  input wire logic CE_I,
  input wire logic [1:0] BUS_MODE_I,
  input wire logic CRYSTAL_I,
  input wire logic REQ_I,
  input wire logic [1:0] KIND_I,
  input wire logic [7:0] DATA_I,
  output logic BUSY_O,
  output logic [7:0] RDATA_O,
  output logic RVALID_O,
  ici_bus_if.host BUS
);
  // ----------------------------------------------------------------
  // access sequencer
  // ----------------------------------------------------------------
  ici_host_state_t state_reg;
  ici_host_state_t state_next;
  ici_acc_t kind_reg;
  ici_acc_t kind_next;
  logic [7:0] wdata_reg;
  logic [7:0] wdata_next;
  logic [15:0] cnt_reg;
  logic [15:0] cnt_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic rvalid_reg;
  logic rvalid_next;
  logic [7:0] data_s;
  logic strobe;
  ici_bus_mode_t mode;

  ici_sync2 #(.W(8), .INIT(8'hff)) u_sync (
    .clk_i(CLK_SYS_I),
    .rst_i(RST_I),
    .ce_i(CE_I),
    .d_i(BUS.data),
    .q_o(data_s)
  );

  always_comb
  begin
    state_next = state_reg;
    kind_next = kind_reg;
    wdata_next = wdata_reg;
    cnt_next = cnt_reg;
    rdata_next = rdata_reg;
    rvalid_next = 1'b0;
    case (state_reg)
      HST_IDLE:
      begin
        if (REQ_I && ici_acc_t'(KIND_I) != ACC_NONE)
        begin
          kind_next = ici_acc_t'(KIND_I);
          wdata_next = DATA_I;
          state_next = HST_SETUP;
        end
      end
      HST_SETUP:
      begin
        cnt_next = 16'(ACC_STROBE_CYC - 4'h1);
        state_next = HST_STROBE;
      end
      HST_STROBE:
      begin
        // the device answers a few cycles into the strobe; sample on the last cycle
        if (cnt_reg == 16'h0000)
        begin
          if (kind_reg == ACC_DATA_RD)
          begin
            rdata_next = data_s;
            rvalid_next = 1'b1;
          end
          cnt_next = 16'(ACC_GAP_CYC - 4'h1);
          state_next = HST_GAP;
        end
        else
          cnt_next = 16'(cnt_reg - 16'h0001);
      end
      HST_GAP:
      begin
        if (cnt_reg == 16'h0000)
        begin
          if (kind_reg == ACC_CMD_WR && wdata_reg == CMD_SYS_SET && CRYSTAL_I)
          begin
            cnt_next = 16'(INIT_WAIT - 1); // R16
            state_next = HST_SETTLE;
          end
          else
            state_next = HST_IDLE;
        end
        else
          cnt_next = 16'(cnt_reg - 16'h0001);
      end
      HST_SETTLE:
      begin
        if (cnt_reg == 16'h0000)
          state_next = HST_IDLE;
        else
          cnt_next = 16'(cnt_reg - 16'h0001);
      end
      default:
        state_next = HST_IDLE;
    endcase
  end

  always_ff @(posedge CLK_SYS_I)
  begin
    if (RST_I)
    begin
      state_reg <= HST_IDLE;
      kind_reg <= ACC_NONE;
      wdata_reg <= 8'h00;
      cnt_reg <= 16'h0000;
      rdata_reg <= 8'h00;
      rvalid_reg <= 1'b0;
    end
    else if (CE_I)
    begin
      state_reg <= state_next;
      kind_reg <= kind_next;
      wdata_reg <= wdata_next;
      cnt_reg <= cnt_next;
      rdata_reg <= rdata_next;
      rvalid_reg <= rvalid_next;
    end
  end

  // ----------------------------------------------------------------
  // pin encoding per bus variant
  // ----------------------------------------------------------------
  assign strobe = (state_reg == HST_STROBE);
  assign mode = ici_bus_mode_t'(BUS_MODE_I);

  always_comb
  begin
    BUS.register_select = (state_reg != HST_IDLE) && (kind_reg != ACC_PAR_WR); // R12 R13 R14
    BUS.wr_n = 1'b1;
    BUS.rd_n = 1'b1;
    BUS.rw = 1'b0;
    BUS.en = 1'b0;
    BUS.lower_byte_strobe_n = 1'b1;
    case (mode)
      BUS_GENERIC:
      begin
        BUS.wr_n = !(strobe && kind_reg != ACC_DATA_RD); // R12
        BUS.rd_n = !(strobe && kind_reg == ACC_DATA_RD);
      end
      BUS_ENABLE:
      begin
        BUS.rw = (kind_reg == ACC_DATA_RD); // R13
        BUS.en = strobe;
      end
      default:
      begin
        BUS.rw = (kind_reg == ACC_DATA_RD); // R14
        BUS.lower_byte_strobe_n = !strobe;
      end
    endcase
  end

  // data is driven from setup through the strobe, never during reads
  assign BUS.host_data = wdata_reg;
  assign BUS.host_data_oe = (state_reg == HST_SETUP || strobe) && (kind_reg != ACC_DATA_RD);
  assign BUSY_O = (state_reg != HST_IDLE);
  assign RDATA_O = rdata_reg;
  assign RVALID_O = rvalid_reg;
endmodule

// >>> tb/ici_sva.sv
// bus checker for the host and device ends of the parallel interface
`timescale 1ns/1ps
module ici_sva (
  input wire logic CLK_SYS_I,
  input wire logic RST_I,
  input wire logic register_select,
  input wire logic wr_n,
  input wire logic rd_n,
  input wire logic en,
  input wire logic lower_byte_strobe_n,
  input wire logic [7:0] host_data,
  input wire logic host_data_oe,
  input wire logic dev_data_oe
);
  default clocking @(posedge CLK_SYS_I); endclocking
  default disable iff (RST_I);

  no_contend_a: assert property (!(host_data_oe && dev_data_oe))
    else $error("both ends drive data");
  wr_width_a: assert property ($fell(wr_n) |-> !wr_n [*8] ##1 wr_n)
    else $error("write strobe width wrong");
  en_width_a: assert property ($rose(en) |-> en [*8] ##1 !en)
    else $error("enable width wrong");
  lds_width_a: assert property ($fell(lower_byte_strobe_n) |->
    !lower_byte_strobe_n [*8] ##1 lower_byte_strobe_n)
    else $error("lower strobe width wrong");
  wr_hold_a: assert property (!wr_n |->
    host_data_oe && $stable(host_data) && $stable(register_select))
    else $error("write data not held");
  rd_answer_a: assert property ($fell(rd_n) |-> ##[1:5] dev_data_oe)
    else $error("read not answered");
  rd_release_a: assert property ($rose(rd_n) |-> ##[1:5] !dev_data_oe)
    else $error("device kept driving");
  rd_nodrive_a: assert property (!rd_n |-> !host_data_oe)
    else $error("host drives during read");
  en_answer_a: assert property (($rose(en) && !host_data_oe) |-> ##[1:5] dev_data_oe)
    else $error("enable read not answered");
  lds_answer_a: assert property (($fell(lower_byte_strobe_n) && !host_data_oe) |->
    ##[1:5] dev_data_oe)
    else $error("lower strobe read not answered");
  wr_gap_a: assert property ($rose(wr_n) |-> wr_n [*3])
    else $error("no idle gap");
endmodule

// >>> tb/tb.sv
// self-checking bench joining host and device ends across the bus
`timescale 1ns/1ps
module tb;
  import ici_pkg::*;
  logic clk, rst, req, crystal, busy, rvalid, standby, normal, disp_on;
  logic [1:0] mode, kind;
  logic [7:0] din, rdata, cfg, rd, v;
  logic [5:0] idx;
  logic [15:0] cursor, cur_m;
  logic [2:0] bpp;
  logic [7:0] reg_m [0:32];
  logic [7:0] mem_m [0:1023];
  logic [7:0] tc [0:7] = '{8'h58, 8'h59, 8'h44, 8'h5d, 8'h5b, 8'h5c, 8'h5a, 8'h60};
  int tn [0:7] = '{1, 1, 10, 2, 1, 2, 1, 1};
  int tbase [0:7] = '{10, 10, 11, 21, 24, 25, 27, 32};
  int err_count, checked, cyc, n;

  ici_bus_if bus ();
  ici_host #(.INIT_WAIT(20)) u_ici_host (.CLK_SYS_I(clk), .RST_I(rst), .CE_I(1'b1),
    .BUS_MODE_I(mode), .CRYSTAL_I(crystal), .REQ_I(req), .KIND_I(kind), .DATA_I(din),
    .BUSY_O(busy), .RDATA_O(rdata), .RVALID_O(rvalid), .BUS(bus.host));
  ici_device u_ici_device (.CLK_SYS_I(clk), .RST_I(rst), .CE_I(1'b1), .BUS_MODE_I(mode),
    .BUS(bus.dev), .CFG_IDX_I(idx), .CFG_DATA_O(cfg), .STANDBY_O(standby),
    .NORMAL_O(normal), .DISPLAY_ON_O(disp_on), .CURSOR_O(cursor), .BPP_O(bpp));
  ici_sva u_ici_sva (.CLK_SYS_I(clk), .RST_I(rst), .register_select(bus.register_select),
    .wr_n(bus.wr_n), .rd_n(bus.rd_n), .en(bus.en),
    .lower_byte_strobe_n(bus.lower_byte_strobe_n), .host_data(bus.host_data),
    .host_data_oe(bus.host_data_oe), .dev_data_oe(bus.dev_data_oe));

  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // op gives up on a hung handshake after 100 busy cycles; also cap the whole run at 6000 cycles
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 6000)
    begin
      err_count++;
      close_out();
    end
  end

  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp)
    begin
      err_count++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic close_out();
    $display("checks %0d errors %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // one host access; n counts busy cycles, rd keeps the read byte
  task automatic op(input logic [1:0] k, input logic [7:0] d);
    @(negedge clk);
    req = 1'b1;
    kind = k;
    din = d;
    @(negedge clk);
    req = 1'b0;
    n = 0;
    rd = 8'hxx;
    while (busy === 1'b1 && n < 100)
    begin
      @(negedge clk);
      n++;
      if (rvalid === 1'b1)
        rd = rdata;
    end
  endtask

  task automatic cfgchk(input int i);
    @(negedge clk);
    idx = i[5:0];
    @(negedge clk);
    chk("cfg", {8'h00, cfg}, {8'h00, reg_m[i]});
  endtask

  task automatic setcur();
    op(1, 8'h46);
    op(2, cur_m[7:0]);
    op(2, cur_m[15:8]);
  endtask

  initial
  begin
    rst = 1'b1;
    req = 1'b0;
    kind = 2'h0;
    din = 8'h00;
    idx = 6'h00;
    mode = 2'h0;
    crystal = 1'b1;
    err_count = 0;
    checked = 0;
    cyc = 0;
    void'($urandom(32'h61bc469a));
    foreach (reg_m[i])
      reg_m[i] = 8'h00;
    repeat (3) @(negedge clk);
    rst = 1'b0;
    chk("standby", standby, 1);
    chk("bpp", bpp, 1);
    op(1, 8'h40);
    chk("wait", n > 20, 1);
    chk("standby", standby, 0);
    for (int i = 0; i < 8; i++)
    begin
      v = 8'($urandom);
      op(2, v);
      reg_m[i] = (i == 0) ? ((v & 8'h2d) | 8'h10) : v;
      chk("normal", normal, i == 7);
    end
    for (int i = 0; i < 8; i++)
      cfgchk(i);
    foreach (tc[j])
    begin
      op(1, tc[j]);
      for (int i = 0; i <= tn[j]; i++)
      begin
        v = 8'($urandom);
        op(2, v);
        if (i < tn[j])
          reg_m[tbase[j] + i] = (tc[j] == 8'h60) ? (v & 8'h03) : v;
      end
      for (int i = 0; i < tn[j]; i++)
        cfgchk(tbase[j] + i);
    end
    chk("disp", disp_on, 1);
    for (int k = 0; k < 4; k++)
    begin
      op(1, 8'h60);
      op(2, k[7:0]);
      chk("bpp", bpp, 16'((k == 3) ? 0 : (1 << k)));
    end
    for (int k = 8'h4c; k <= 8'h4f; k++)
    begin
      op(1, k[7:0]);
      reg_m[23] = 8'(k & 3);
      cfgchk(23);
    end
    // value 3 of the strap must behave as the lower-strobe bus
    for (int m = 0; m < 4; m++)
    begin
      mode = m[1:0];
      repeat (4) @(negedge clk);
      cur_m = 16'($urandom_range(1000));
      setcur();
      chk("cursor", cursor, cur_m);
      op(1, 8'h42);
      for (int i = 0; i < 4; i++)
      begin
        v = 8'($urandom);
        op(2, v);
        mem_m[cur_m + i] = v;
      end
      chk("cursor", cursor, cur_m + 16'h4);
      setcur();
      op(1, 8'h43);
      for (int i = 0; i < 4; i++)
      begin
        op(3, 8'h00);
        chk("mem", rd, mem_m[cur_m + i]);
      end
      op(1, 8'h47);
      op(3, 8'h00);
      chk("curlo", rd, 8'(cur_m + 16'h4));
      op(3, 8'h00);
      chk("curhi", rd, 8'((cur_m + 16'h4) >> 8));
    end
    op(1, 8'h53);
    chk("standby", standby, 1);
    chk("normal", normal, 0);
    reg_m[8] = 8'h01;
    cfgchk(8);
    // without a crystal the init code needs no settle wait
    crystal = 1'b0;
    op(1, 8'h40);
    chk("nowait", n < 20, 1);
    chk("standby", standby, 0);
    chk("normal", normal, 0);
    close_out();
  end
endmodule
